// ===== crex_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Thirty-two level-sensitive interrupt inputs, sampled
// - Interrupt when enable, request, and mask
// - Software-writable per-line interrupt mask register
// - No hardware priority; nesting allowed
// - All exceptions go to one address
// - Exception address fixed at generation
// - Mul/div trap when hardware absent
// - Global reset acts immediately
// - Local reset drains pipeline first
// - One-cycle done pulse, repeated while held
// - Stay in reset while request held
// - In reset, periodic discarded reset reads
// - Ignore local reset raised under debug; debug in drain or hold has no effect
// - User mode cannot write control registers
// - Vector helper uses priority encoder
// - Helper negative if none or gie low; else 8*index
module crex_ctrl
    import crex_pkg::*;
#(
    parameter logic [ADDR_W-1:0] EXC_ADDR = 32'h0000_0020,
    parameter logic [ADDR_W-1:0] RST_ADDR = 32'h0000_0000,
    parameter bit HAS_MULDIV = 1'b0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Interrupt pins
    input wire logic [IRQ_W-1:0] irq,
    // Local reset and debug
    input wire logic reset_req,
    input wire logic debug_hold,
    output logic reset_done,
    output logic in_reset,
    // Pipeline status
    input wire logic pipe_empty,
    input wire logic issue_valid,
    input wire logic issue_muldiv,
    input wire logic issue_trap,
    input wire logic eret,
    // Control register access
    input wire logic ctl_wr,
    input wire logic [CTL_SEL_W-1:0] ctl_sel,
    input wire logic [DATA_W-1:0] ctl_wdata,
    output logic [DATA_W-1:0] ctl_rdata,
    output logic ctl_denied,
    // Exception redirect
    output logic exc_take,
    output logic [ADDR_W-1:0] exc_pc,
    output logic irq_pending,
    // Reset-hold reads
    output logic rst_rd,
    output logic [ADDR_W-1:0] rst_rd_addr,
    input wire logic rst_rd_valid,
    input wire logic [DATA_W-1:0] rst_rd_data,
    // Vector helper
    output logic [DATA_W-1:0] vector_helper_instruction
);
    typedef enum logic [1:0] {CREX_RUN, CREX_DRAIN, CREX_HOLD} crex_state_t;
    crex_state_t state_r;
    logic [IRQ_W-1:0] irq_s1_r;
    logic [IRQ_W-1:0] irq_s2_r;
    logic req_s1_r;
    logic req_s2_r;
    logic dbg_s1_r;
    logic dbg_s2_r;
    logic [DATA_W-1:0] status_r;
    logic [DATA_W-1:0] estatus_r;
    logic [DATA_W-1:0] bstatus_r;
    logic [IRQ_W-1:0] ienable_r;
    logic [IRQ_W-1:0] pending;
    logic [CNT_W-1:0] cnt_r;
    logic hw_irq;
    logic user_mode;
    logic muldiv_exc;
    logic req_act;
    logic exc_take_r;
    logic [DATA_W-1:0] ctl_rdata_r;
    logic ctl_denied_r;
    logic reset_done_r;
    logic rst_rd_r;
    logic discard_r;

    // Pin synchronisers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_s1_r <= '0;
            irq_s2_r <= '0;
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            dbg_s1_r <= 1'b0;
            dbg_s2_r <= 1'b0;
        end else if (clk_en) begin
            irq_s1_r <= irq;
            irq_s2_r <= irq_s1_r;
            req_s1_r <= reset_req;
            req_s2_r <= req_s1_r;
            dbg_s1_r <= debug_hold;
            dbg_s2_r <= dbg_s1_r;
        end
    end

    // Per-line pending gates
    genvar g;
    generate
        for (g = 0; g < IRQ_W; g++) begin : g_pend
            assign pending[g] = irq_s2_r[g] & ienable_r[g];
        end
    endgenerate

    // Any enabled line qualifies, no ranking
    assign hw_irq = status_r[ST_GIE_BIT] && (|pending);
    assign user_mode = status_r[ST_USER_BIT];
    assign muldiv_exc = !HAS_MULDIV && issue_valid && issue_muldiv;
    assign req_act = req_s2_r && !dbg_s2_r;

    // Exception entry, one shared target
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            exc_take_r <= 1'b0;
        end else if (clk_en) begin
            exc_take_r <= (state_r == CREX_RUN) && issue_valid
                && (hw_irq || muldiv_exc || issue_trap);
        end
    end
    assign exc_take = exc_take_r;
    assign exc_pc = EXC_ADDR;
    assign irq_pending = hw_irq;

    // Status: saved on entry, restored on return
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= STATUS_RST;
            estatus_r <= STATUS_RST;
            bstatus_r <= STATUS_RST;
        end else if (clk_en) begin
            if (state_r == CREX_HOLD) begin
                status_r <= STATUS_RST;
            end else if (exc_take_r) begin
                estatus_r <= status_r;
                status_r <= STATUS_RST;
            end else if (eret) begin
                status_r <= estatus_r;
            end else if (ctl_wr && !user_mode) begin
                case (ctl_sel)
                    CTL_STATUS: status_r <= ctl_wdata;
                    CTL_ESTATUS: estatus_r <= ctl_wdata;
                    CTL_BSTATUS: bstatus_r <= ctl_wdata;
                    default: ;
                endcase
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ienable_r <= IENABLE_RST;
        end else if (clk_en) begin
            if (state_r == CREX_HOLD) begin
                ienable_r <= IENABLE_RST;
            end else if (ctl_wr && !user_mode && ctl_sel == CTL_IENABLE) begin
                ienable_r <= ctl_wdata;
            end
        end
    end

    // Control read port and privilege refusal
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_rdata_r <= '0;
            ctl_denied_r <= 1'b0;
        end else if (clk_en) begin
            ctl_denied_r <= ctl_wr && user_mode;
            case (ctl_sel)
                CTL_STATUS: ctl_rdata_r <= status_r;
                CTL_ESTATUS: ctl_rdata_r <= estatus_r;
                CTL_BSTATUS: ctl_rdata_r <= bstatus_r;
                CTL_IENABLE: ctl_rdata_r <= ienable_r;
                CTL_IPENDING: ctl_rdata_r <= pending;
                CTL_CPUID: ctl_rdata_r <= CPUID_VAL;
                default: ctl_rdata_r <= '0;
            endcase
        end
    end
    assign ctl_rdata = ctl_rdata_r;
    assign ctl_denied = ctl_denied_r;

    // Local reset sequencing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= CREX_RUN;
        end else if (clk_en) begin
            case (state_r)
                CREX_RUN: begin
                    if (req_act) begin
                        state_r <= CREX_DRAIN;
                    end
                end
                CREX_DRAIN: begin
                    if (pipe_empty) begin
                        state_r <= CREX_HOLD;
                    end
                end
                CREX_HOLD: begin
                    if (!req_s2_r) begin
                        state_r <= CREX_RUN;
                    end
                end
                default: state_r <= CREX_RUN;
            endcase
        end
    end
    assign in_reset = (state_r == CREX_HOLD);

    // Hold-period counter: done pulse and reset reads
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= CNT_ZERO;
            reset_done_r <= 1'b0;
            rst_rd_r <= 1'b0;
        end else if (clk_en) begin
            reset_done_r <= 1'b0;
            rst_rd_r <= 1'b0;
            if (state_r == CREX_DRAIN && pipe_empty) begin
                cnt_r <= CNT_W'(TAKEN_PERIOD_CYC - 1);
                reset_done_r <= 1'b1;
                rst_rd_r <= 1'b1;
            end else if (state_r == CREX_HOLD && req_s2_r) begin
                if (cnt_r == CNT_ZERO) begin
                    cnt_r <= CNT_W'(TAKEN_PERIOD_CYC - 1);
                    reset_done_r <= 1'b1;
                    rst_rd_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - CNT_ONE;
                end
            end else begin
                cnt_r <= CNT_ZERO;
            end
        end
    end
    assign reset_done = reset_done_r;
    assign rst_rd = rst_rd_r;
    assign rst_rd_addr = RST_ADDR;

    // Returned reset-read data is dropped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            discard_r <= 1'b0;
        end else if (clk_en) begin
            // Return is only noted; its data has no sink
            discard_r <= rst_rd_valid;
        end
    end

    crex_prio_enc u_enc (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pend(pending),
        .gie(status_r[ST_GIE_BIT]),
        .vec_r(vector_helper_instruction)
    );
endmodule : crex_ctrl

// ===== crex_ctrl_monitor.sv
`timescale 1ns/1ps
module crex_ctrl_mon
    import crex_pkg::*;
#(
    parameter logic [ADDR_W-1:0] EXC_ADDR = 32'h0000_0020,
    parameter logic [ADDR_W-1:0] RST_ADDR = 32'h0000_0000,
    parameter bit HAS_MULDIV = 1'b0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Requests
    input wire logic [IRQ_W-1:0] irq,
    input wire logic reset_req,
    input wire logic debug_hold,
    input wire logic pipe_empty,
    input wire logic issue_valid,
    input wire logic issue_muldiv,
    // Outputs watched
    input wire logic reset_done,
    input wire logic in_reset,
    input wire logic exc_take,
    input wire logic [ADDR_W-1:0] exc_pc,
    input wire logic irq_pending,
    input wire logic rst_rd,
    input wire logic [ADDR_W-1:0] rst_rd_addr,
    input wire logic [DATA_W-1:0] vector_helper_instruction
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence req_settled;
        (reset_req && !debug_hold && pipe_empty && clk_en) [*6];
    endsequence
    sequence debug_owns;
        (debug_hold && !in_reset) [*3];
    endsequence
    exc_addr_fixed_a: assert property (exc_pc == EXC_ADDR)
        else $error("exception address moved");
    rst_addr_fixed_a: assert property (rst_rd_addr == RST_ADDR)
        else $error("reset read address moved");
    done_one_cycle_a: assert property (reset_done |=> !reset_done)
        else $error("reset done longer than one cycle");
    done_with_read_a: assert property (reset_done |-> rst_rd && in_reset)
        else $error("reset done without reset read");
    pend_needs_line_a: assert property ((irq == '0) [*3] |-> !irq_pending)
        else $error("pending with all lines low");
    vector_shape_a: assert property (vector_helper_instruction != VEC_NONE
        |-> vector_helper_instruction[2:0] == 3'h0 && vector_helper_instruction[31:8] == '0)
        else $error("vector not eight times an index");
    muldiv_trap_a: assert property (issue_valid && issue_muldiv && clk_en && !in_reset
        && !HAS_MULDIV |=> exc_take)
        else $error("mul or div issued without exception");
    hold_stays_a: assert property (reset_req [*3] ##0 in_reset |=> in_reset)
        else $error("left reset with request held");
    drain_enters_a: assert property (req_settled |-> in_reset)
        else $error("local reset not entered");
    debug_ignore_a: assert property (debug_owns |=> !in_reset)
        else $error("reset entered under debug");
endmodule : crex_ctrl_mon
bind crex_ctrl crex_ctrl_mon #(.EXC_ADDR(EXC_ADDR), .RST_ADDR(RST_ADDR), .HAS_MULDIV(HAS_MULDIV))
    i_mon (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .irq(irq), .reset_req(reset_req),
    .debug_hold(debug_hold), .pipe_empty(pipe_empty), .issue_valid(issue_valid),
    .issue_muldiv(issue_muldiv), .reset_done(reset_done), .in_reset(in_reset),
    .exc_take(exc_take), .exc_pc(exc_pc), .irq_pending(irq_pending), .rst_rd(rst_rd),
    .rst_rd_addr(rst_rd_addr), .vector_helper_instruction(vector_helper_instruction));

// ===== crex_periph_model.sv
`timescale 1ns/1ps
module crex_periph_model
    import crex_pkg::*;
#(
    parameter int RD_LAT = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Source levels and pins
    input wire logic [IRQ_W-1:0] irq_lvl,
    output logic [IRQ_W-1:0] irq,
    // Reset-address memory
    input wire logic rst_rd,
    output logic rst_rd_valid,
    output logic [DATA_W-1:0] rst_rd_data
);
    logic [RD_LAT-1:0] lat_r;
    logic [DATA_W-1:0] junk_r;
    // Sources hold their level until serviced
    assign irq = irq_lvl;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_r <= '0;
            junk_r <= 32'h5a5a_a5a5;
        end else begin
            lat_r <= {lat_r[RD_LAT-2:0], rst_rd};
            junk_r <= ~junk_r;
        end
    end
    // Slow answer; data changes every cycle so any kept value shows
    assign rst_rd_valid = lat_r[RD_LAT-1];
    assign rst_rd_data = junk_r;
endmodule : crex_periph_model

// ===== crex_pkg.sv
package crex_pkg;
    localparam int IRQ_W = 32;
    localparam int IDX_W = 5;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int NUM_CTL = 6;
    localparam int CTL_SEL_W = 3;
    // Control register indices
    localparam logic [2:0] CTL_STATUS = 3'h0;
    localparam logic [2:0] CTL_ESTATUS = 3'h1;
    localparam logic [2:0] CTL_BSTATUS = 3'h2;
    localparam logic [2:0] CTL_IENABLE = 3'h3;
    localparam logic [2:0] CTL_IPENDING = 3'h4;
    localparam logic [2:0] CTL_CPUID = 3'h5;
    // Status field positions
    localparam int ST_GIE_BIT = 0;
    localparam int ST_USER_BIT = 1;
    localparam logic [31:0] STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] IENABLE_RST = 32'h0000_0000;
    // Arbitrary identification value
    localparam logic [31:0] CPUID_VAL = 32'h0000_0001;
    localparam logic [31:0] VEC_NONE = 32'hffff_ffff;
    localparam int VEC_SHIFT = 3;
    // Reset hold timing
    localparam int CLK_MHZ = 50;
    localparam int TAKEN_PERIOD_NS = 320;
    localparam int TAKEN_PERIOD_CYC = (TAKEN_PERIOD_NS * CLK_MHZ) / 1000;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_ZERO = 8'h00;
endpackage : crex_pkg

// ===== crex_prio_enc.sv
`timescale 1ns/1ps
module crex_prio_enc
    import crex_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Pending view
    input wire logic [IRQ_W-1:0] pend,
    input wire logic gie,
    // Result, registered
    output logic [DATA_W-1:0] vec_r
);
    logic [IDX_W-1:0] idx;
    logic found;
    always_comb begin
        idx = '0;
        found = 1'b0;
        for (int i = IRQ_W - 1; i >= 0; i--) begin
            if (pend[i]) begin
                idx = IDX_W'(i);
                found = 1'b1;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_r <= VEC_NONE;
        end else if (clk_en) begin
            if (!found || !gie) begin
                vec_r <= VEC_NONE;
            end else begin
                vec_r <= DATA_W'({idx, VEC_SHIFT'(0)});
            end
        end
    end
endmodule : crex_prio_enc

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
    import crex_pkg::*;
    logic core_clk, rst_n, clk_en, reset_req, debug_hold, pipe_empty, eret, ctl_wr;
    logic issue_valid, issue_muldiv, issue_trap, reset_done, in_reset, ctl_denied;
    logic exc_take, irq_pending, rst_rd, rst_rd_valid;
    logic [2:0] ctl_sel;
    logic [31:0] irq, irq_lvl, ctl_wdata, ctl_rdata, exc_pc, rst_rd_addr, rst_rd_data, vec, d;
    int n_mismatch, compares, n;
    crex_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .irq(irq),
        .reset_req(reset_req), .debug_hold(debug_hold), .reset_done(reset_done),
        .in_reset(in_reset), .pipe_empty(pipe_empty), .issue_valid(issue_valid),
        .issue_muldiv(issue_muldiv), .issue_trap(issue_trap), .eret(eret), .ctl_wr(ctl_wr),
        .ctl_sel(ctl_sel), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
        .ctl_denied(ctl_denied), .exc_take(exc_take), .exc_pc(exc_pc),
        .irq_pending(irq_pending), .rst_rd(rst_rd), .rst_rd_addr(rst_rd_addr),
        .rst_rd_valid(rst_rd_valid), .rst_rd_data(rst_rd_data), .vector_helper_instruction(vec));
    crex_periph_model i_far (.core_clk(core_clk), .rst_n(rst_n), .irq_lvl(irq_lvl), .irq(irq),
        .rst_rd(rst_rd), .rst_rd_valid(rst_rd_valid), .rst_rd_data(rst_rd_data));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task conclude;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick
    task ctl_write(input logic [2:0] sel, input logic [31:0] v);
        @(posedge core_clk);
        ctl_wr <= 1'b1;
        ctl_sel <= sel;
        ctl_wdata <= v;
        @(posedge core_clk);
        ctl_wr <= 1'b0;
    endtask : ctl_write
    task ctl_read(input logic [2:0] sel, output logic [31:0] v);
        @(posedge core_clk);
        ctl_sel <= sel;
        tick(1);
        v = ctl_rdata;
    endtask : ctl_read
    task issue(input logic md, input logic tr, input logic exp);
        @(posedge core_clk);
        issue_valid <= 1'b1;
        issue_muldiv <= md;
        issue_trap <= tr;
        @(posedge core_clk);
        issue_valid <= 1'b0;
        issue_muldiv <= 1'b0;
        issue_trap <= 1'b0;
        #1;
        check({31'h0, exc_take}, {31'h0, exp});
    endtask : issue
    task wait_done;
        n = 0;
        while (reset_done !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        if (reset_done !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
    endtask : wait_done
    initial begin
        {rst_n, reset_req, debug_hold, pipe_empty, eret, ctl_wr, issue_valid} = '0;
        {issue_muldiv, issue_trap, ctl_sel, ctl_wdata, irq_lvl} = '0;
        clk_en = 1'b1;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        tick(2);
        check(vec, VEC_NONE);
        ctl_write(CTL_IENABLE, 32'hffff_ffff);
        ctl_write(CTL_STATUS, 32'h0000_0001);
        for (int i = 0; i < 32; i++) begin
            @(posedge core_clk);
            irq_lvl <= 32'h0000_0001 << i;
            tick(5);
            check(vec, 32'(i * 8));
            check({31'h0, irq_pending}, 32'h1);
        end
        @(posedge core_clk);
        irq_lvl <= 32'h0000_0220;
        tick(5);
        check(vec, 32'h0000_0028);
        @(posedge core_clk);
        clk_en <= 1'b0;
        irq_lvl <= 32'h0000_0200;
        tick(5);
        check(vec, 32'h0000_0028);
        @(posedge core_clk);
        clk_en <= 1'b1;
        tick(5);
        check(vec, 32'h0000_0048);
        @(posedge core_clk);
        irq_lvl <= 32'h0000_0220;
        tick(5);
        ctl_write(CTL_IENABLE, 32'h0000_0200);
        tick(3);
        check(vec, 32'h0000_0048);
        ctl_read(CTL_IPENDING, d);
        check(d, 32'h0000_0200);
        ctl_read(CTL_IENABLE, d);
        check(d, 32'h0000_0200);
        ctl_read(CTL_CPUID, d);
        check(d, CPUID_VAL);
        ctl_write(CTL_STATUS, 32'h0000_0000);
        tick(3);
        check({31'h0, irq_pending}, 32'h0);
        check(vec, VEC_NONE);
        ctl_write(CTL_STATUS, 32'h0000_0001);
        issue(1'b0, 1'b0, 1'b1);
        issue(1'b1, 1'b0, 1'b1);
        check(exc_pc, 32'h0000_0020);
        check(rst_rd_addr, 32'h0000_0000);
        issue(1'b0, 1'b0, 1'b0);
        ctl_write(CTL_STATUS, 32'h0000_0002);
        ctl_write(CTL_IENABLE, 32'hffff_ffff);
        #1;
        check({31'h0, ctl_denied}, 32'h1);
        ctl_read(CTL_IENABLE, d);
        check(d, 32'h0000_0200);
        issue(1'b0, 1'b1, 1'b1);
        ctl_read(CTL_STATUS, d);
        check(d, 32'h0000_0000);
        @(posedge core_clk);
        eret <= 1'b1;
        @(posedge core_clk);
        eret <= 1'b0;
        ctl_read(CTL_STATUS, d);
        check(d, 32'h0000_0002);
        @(posedge core_clk);
        debug_hold <= 1'b1;
        reset_req <= 1'b1;
        pipe_empty <= 1'b1;
        tick(10);
        check({31'h0, in_reset}, 32'h0);
        @(posedge core_clk);
        debug_hold <= 1'b0;
        pipe_empty <= 1'b0;
        tick(8);
        check({31'h0, in_reset}, 32'h0);
        @(posedge core_clk);
        pipe_empty <= 1'b1;
        wait_done();
        check({31'h0, rst_rd}, 32'h1);
        tick(1);
        check({31'h0, reset_done}, 32'h0);
        wait_done();
        check(32'(n), 32'(TAKEN_PERIOD_CYC - 1));
        tick(20);
        check({31'h0, in_reset}, 32'h1);
        @(posedge core_clk);
        reset_req <= 1'b0; // Requester releases the core
        tick(6);
        check({31'h0, in_reset}, 32'h0);
        @(posedge core_clk);
        reset_req <= 1'b1;
        wait_done();
        @(posedge core_clk);
        rst_n <= 1'b0;
        #1;
        check({31'h0, in_reset}, 32'h0);
        check(vec, VEC_NONE);
        conclude();
    end
endmodule : testbench
